// ### src/cci_pkg.sv
// constants for the comparator change-detect and control block
// assumes a single 10 MHz clock and an AXI4-Lite register bus
package cci_pkg;
  localparam logic [7:0] CCI_CTRL_OFS = 8'h00;
  localparam logic [7:0] CCI_FLAG_OFS = 8'h04;
  localparam logic [7:0] CCI_EN_OFS = 8'h08;
  localparam logic [7:0] CCI_STAT_OFS = 8'h0c;
  localparam logic [7:0] CCI_CTRL_RST = 8'h00;
  localparam int CCI_ON_BIT = 7;
  localparam int CCI_OUT_BIT = 6;
  localparam int CCI_OE_BIT = 5;
  localparam int CCI_POL_BIT = 4;
  localparam int CCI_RSV_BIT = 3;
  localparam int CCI_REF_BIT = 2;
  localparam logic [7:0] CCI_CTRL_WMASK = 8'hb7;
  localparam int CCI_EN_CMP_BIT = 0;
  localparam int CCI_EN_PER_BIT = 1;
  localparam int CCI_EN_GLB_BIT = 2;
  localparam logic [1:0] CCI_RESP_OKAY = 2'h0;
  localparam logic [1:0] CCI_RESP_SLVERR = 2'h2;
  localparam int CCI_PHASES = 4;
endpackage

// ### src/cci_comparator.sv
// comparator digital control, mismatch detect and interrupt flag
// assumes an analog compare result synchronous to clk
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module cci_comparator
  import cci_pkg::*;
(
  input wire logic clk, // 10 MHz clock
  input wire logic nrst, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read response valid
  input wire logic s_axi_rready, // read response ready
  input wire logic analog_gt, // analog: selected plus above minus
  input wire logic sleeping, // core is in sleep
  output logic comparator_enable, // analog comparator powered
  output logic internal_reference_sel, // plus input from reference
  output logic [1:0] negative_pin_sel, // minus input pin number
  output logic output_pin_drive, // result drive onto output pin
  output logic output_pin_en, // output pin override enable
  output logic core_irq, // interrupt request to core
  output logic wake_req // wake from sleep request
);
  // ==========================================================
  // phase-one strobe divider
  logic [1:0] phase_q;
  wire phase_one_clock = (phase_q == 2'h0);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1;

  // ==========================================================
  // control register and result
  logic [7:0] ctrl_q;
  logic flag_q;
  logic [2:0] en_q;
  logic held_q;
  logic samp_q;
  logic mism_q;
  logic res_q;

  wire raw_result = analog_gt ^ ctrl_q[CCI_POL_BIT];
  wire comparator_result = ctrl_q[CCI_ON_BIT] & raw_result;
  wire [7:0] ctrl_rd = {ctrl_q[7], res_q, ctrl_q[5:4], 1'b0, ctrl_q[2:0]};

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      res_q <= 1'b0;
    else if (phase_one_clock)
      res_q <= comparator_result;

  assign comparator_enable = ctrl_q[CCI_ON_BIT];
  assign internal_reference_sel = ctrl_q[CCI_REF_BIT];
  assign negative_pin_sel = ctrl_q[1:0];
  assign output_pin_en = ctrl_q[CCI_OE_BIT];
  assign output_pin_drive = ctrl_q[CCI_OE_BIT] & res_q;

  // ==========================================================
  // axi4-lite slave
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_q && w_q;

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == CCI_CTRL_OFS) || (a == CCI_FLAG_OFS)
             || (a == CCI_EN_OFS) || (a == CCI_STAT_OFS);
  endfunction

  wire wr_ctrl = wr_go && (awaddr_q == CCI_CTRL_OFS) && wstrb_q[0];
  wire wr_flag = wr_go && (awaddr_q == CCI_FLAG_OFS) && wstrb_q[0];
  wire wr_en = wr_go && (awaddr_q == CCI_EN_OFS) && wstrb_q[0];
  wire rd_ctrl = ar_take && (s_axi_araddr == CCI_CTRL_OFS);
  // a control write begins with an internal read
  wire ctrl_touch = rd_ctrl || (wr_go && awaddr_q == CCI_CTRL_OFS);

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (s_axi_araddr)
      CCI_CTRL_OFS: rd_mux = {24'h0, ctrl_rd};
      CCI_FLAG_OFS: rd_mux = {31'h0, flag_q};
      CCI_EN_OFS: rd_mux = {29'h0, en_q};
      CCI_STAT_OFS: rd_mux = {29'h0, mism_q, samp_q, held_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      bresp_q <= CCI_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        bresp_q <= known_ofs(awaddr_q) ? CCI_RESP_OKAY : CCI_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= CCI_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= known_ofs(s_axi_araddr) ? CCI_RESP_OKAY : CCI_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;

  // ==========================================================
  // register writes
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ctrl_q <= CCI_CTRL_RST;
      en_q <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= wdata_q[7:0] & CCI_CTRL_WMASK;
      if (wr_en)
        en_q <= wdata_q[2:0];
    end

  // ==========================================================
  // mismatch circuit, independent of output enable
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      held_q <= 1'b0;
      samp_q <= 1'b0;
      mism_q <= 1'b0;
    end
    else
    begin
      if (ctrl_touch)
        held_q <= samp_q;
      if (phase_one_clock)
        samp_q <= comparator_result;
      mism_q <= held_q ^ samp_q;
    end

  // rising edge of mismatch; a touch masks it, the documented race
  wire mism_now = held_q ^ samp_q;
  wire mism_rise = mism_now && !mism_q && !ctrl_touch;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      flag_q <= 1'b0;
    else if (mism_rise)
      flag_q <= 1'b1;
    else if (wr_flag)
      flag_q <= wdata_q[0];

  // ==========================================================
  // interrupt and wake
  wire cmp_per = en_q[CCI_EN_CMP_BIT] && en_q[CCI_EN_PER_BIT];
  assign core_irq = flag_q && cmp_per && en_q[CCI_EN_GLB_BIT] && !sleeping;
  assign wake_req = flag_q && cmp_per && sleeping;

  // ==========================================================
  // assertions

  sequence s_touch;
    ctrl_touch;
  endsequence
  sequence s_quiet;
    !mism_now;
  endsequence
  sequence s_change;
    mism_now && !ctrl_touch;
  endsequence

  a_wake_no_global: assert property (@(posedge clk) disable iff (!nrst)
    (sleeping && flag_q && cmp_per) |-> wake_req)
    else $error("wake missing");

  a_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    core_irq |-> (flag_q && en_q == 3'h7))
    else $error("irq not gated");

  a_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    mism_rise |=> flag_q)
    else $error("flag not set");

  a_samp_phase: assert property (@(posedge clk) disable iff (!nrst)
    !$past(phase_one_clock) |-> $stable(samp_q))
    else $error("sample off phase");

  a_held_read: assert property (@(posedge clk) disable iff (!nrst)
    s_touch |=> held_q == $past(samp_q))
    else $error("held not captured");

  a_held_keep: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl_touch |=> $stable(held_q))
    else $error("held changed");

  a_rsv_zero: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q[CCI_RSV_BIT] == 1'b0)
    else $error("reserved bit set");

  a_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wr_flag && !wdata_q[0] && !mism_rise) |=> !flag_q)
    else $error("flag not cleared");

  a_off_result: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl_q[CCI_ON_BIT] |-> !comparator_result)
    else $error("off but result");

  a_samp_take: assert property (@(posedge clk) disable iff (!nrst)
    phase_one_clock |=> samp_q == $past(comparator_result))
    else $error("sample not taken");

  a_mism_reg: assert property (@(posedge clk) disable iff (!nrst)
    nrst |=> mism_q == $past(mism_now))
    else $error("mismatch register wrong");

  a_touch_clear: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_touch && !phase_one_clock) |=> !mism_now)
    else $error("mismatch not cleared");

  a_mism_persist: assert property (@(posedge clk) disable iff (!nrst)
    (mism_now && !ctrl_touch && !phase_one_clock) |=> mism_now)
    else $error("mismatch lost");

  a_no_edge_flag: assert property (@(posedge clk) disable iff (!nrst)
    (!flag_q && !mism_rise && !wr_flag) |=> !flag_q)
    else $error("flag set without edge");

  a_flag_keep: assert property (@(posedge clk) disable iff (!nrst)
    (flag_q && !wr_flag) |=> flag_q)
    else $error("flag dropped");

  a_flag_sw_set: assert property (@(posedge clk) disable iff (!nrst)
    (wr_flag && wdata_q[0]) |=> flag_q)
    else $error("software set lost");

  a_irq_need: assert property (@(posedge clk) disable iff (!nrst)
    (flag_q && en_q == 3'h7 && !sleeping) |-> core_irq)
    else $error("irq missing");

  a_wake_gate: assert property (@(posedge clk) disable iff (!nrst)
    wake_req |-> (sleeping && flag_q && en_q[CCI_EN_CMP_BIT] && en_q[CCI_EN_PER_BIT]))
    else $error("wake not gated");

  a_sleep_no_irq: assert property (@(posedge clk) disable iff (!nrst)
    sleeping |-> !core_irq)
    else $error("vector during sleep");

  a_ctrl_hold: assert property (@(posedge clk) disable iff (!nrst)
    !wr_ctrl |=> $stable(ctrl_q))
    else $error("control changed");

  a_en_hold: assert property (@(posedge clk) disable iff (!nrst)
    !wr_en |=> $stable(en_q))
    else $error("enables changed");

  a_pin_drive: assert property (@(posedge clk) disable iff (!nrst)
    output_pin_drive |-> output_pin_en)
    else $error("pin driven while internal");

  a_res_phase: assert property (@(posedge clk) disable iff (!nrst)
    !$past(phase_one_clock) |-> $stable(res_q))
    else $error("result off phase");

  a_rd_zero: assert property (@(posedge clk) disable iff (!nrst)
    rd_ctrl |=> s_axi_rdata[CCI_RSV_BIT] == 1'b0)
    else $error("reserved bit read");

  a_rd_result: assert property (@(posedge clk) disable iff (!nrst)
    rd_ctrl |=> s_axi_rdata[CCI_OUT_BIT] == $past(res_q))
    else $error("result bit wrong");

  a_phase_once: assert property (@(posedge clk) disable iff (!nrst)
    phase_one_clock |=> !phase_one_clock)
    else $error("strobe too long");

  a_phase_period: assert property (@(posedge clk) disable iff (!nrst)
    phase_one_clock |-> ##4 phase_one_clock)
    else $error("strobe period wrong");

  a_rise_quiet: assert property (@(posedge clk) disable iff (!nrst)
    s_quiet ##1 s_change |=> flag_q)
    else $error("return edge missed");

  a_touch_drop: assert property (@(posedge clk) disable iff (!nrst)
    s_touch |-> !mism_rise)
    else $error("edge during touch");

endmodule // cci_comparator

// ### test/cci_analog_model.sv
// analog front end model: selects plus and minus levels and compares
// assumes levels are plain unsigned codes, settled before each clk edge
`timescale 1ns/1ns
module cci_analog_model
(
  input wire logic [7:0] pos_lvl, // plus pin level
  input wire logic [7:0] ref_lvl, // internal reference level
  input wire logic [31:0] neg_lvls, // four minus pin levels, pin 0 low byte
  input wire logic ref_sel, // plus taken from reference
  input wire logic [1:0] neg_sel, // minus pin number
  output logic gt // plus above minus
);
  logic [7:0] plus_v;
  logic [7:0] minus_v;
  assign plus_v = ref_sel ? ref_lvl : pos_lvl;
  assign minus_v = neg_lvls[neg_sel*8 +: 8];
  assign gt = plus_v > minus_v;
endmodule // cci_analog_model

// ### test/tb_top.sv
// testbench: register accesses over axi4-lite with expected values
// assumes the analog model drives the compare result
`timescale 1ns/1ns
module tb_top
  import cci_pkg::*;
;
  logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, analog_gt, sleeping, comparator_enable, internal_reference_sel;
  logic output_pin_drive, output_pin_en, core_irq, wake_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pos_lvl, ref_lvl;
  logic [31:0] s_axi_wdata, s_axi_rdata, neg_lvls, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, negative_pin_sel, rsp;
  int fails, n_checks;
  // ==========================================================
  // instances
  cci_comparator dut_u (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_gt, .sleeping,
    .comparator_enable, .internal_reference_sel, .negative_pin_sel, .output_pin_drive,
    .output_pin_en, .core_irq, .wake_req);
  cci_analog_model afe_u (.pos_lvl, .ref_lvl, .neg_lvls, .ref_sel(internal_reference_sel),
    .neg_sel(negative_pin_sel), .gt(analog_gt));
  always #50 clk = ~clk;
  // ==========================================================
  // tasks
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one access; w selects write, holds each valid until its ready
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do
    begin
      @(posedge clk);
      k++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready) && !(s_axi_rvalid && s_axi_rready) && k < 40);
    rsp = w ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
    if (k >= 40)
    begin
      fails++;
      close_out;
    end
  endtask
  // ==========================================================
  // sequence
  initial
  begin
    {clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, sleeping} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {fails, n_checks} = '0;
    s_axi_wstrb = 4'h1;
    pos_lvl = 8'h40;
    ref_lvl = 8'h80;
    neg_lvls = 32'h10305070;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    xfer(0, CCI_CTRL_OFS, 0);
    chk("ctrl reset", 32'h0, rd);
    xfer(0, 8'h40, 0);
    chk("unmapped resp", CCI_RESP_SLVERR, rsp);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1, CCI_CTRL_OFS, 32'h80 | i);
      repeat (5) @(posedge clk);
      xfer(0, CCI_CTRL_OFS, 0);
      chk("channel ctrl", 32'h80 | i | (i > 1 ? 32'h40 : 32'h0), rd);
      chk("minus sel", i, negative_pin_sel);
    end
    xfer(1, CCI_CTRL_OFS, 32'hfc);
    repeat (5) @(posedge clk);
    xfer(0, CCI_CTRL_OFS, 0);
    chk("ctrl inverted", 32'hb4, rd);
    chk("pin en ref", 32'h3, {output_pin_en, internal_reference_sel});
    chk("pin drive inv", 32'h0, output_pin_drive);
    xfer(1, CCI_CTRL_OFS, 32'he4);
    repeat (5) @(posedge clk);
    xfer(0, CCI_CTRL_OFS, 0);
    chk("ctrl plain", 32'he4, rd);
    chk("pin drive", 1'b1, output_pin_drive);
    xfer(1, CCI_EN_OFS, 32'h7);
    xfer(1, CCI_CTRL_OFS, 32'ha0);
    repeat (5) @(posedge clk);
    xfer(0, CCI_CTRL_OFS, 0);
    chk("ctrl settled", 32'ha0, rd);
    xfer(1, CCI_FLAG_OFS, 0);
    pos_lvl <= 8'h90;
    repeat (6) @(posedge clk);
    xfer(0, CCI_FLAG_OFS, 0);
    chk("flag on change", 32'h1, rd);
    chk("irq all enables", 1'b1, core_irq);
    xfer(1, CCI_FLAG_OFS, 0);
    xfer(0, CCI_FLAG_OFS, 0);
    chk("flag cleared", 32'h0, rd);
    xfer(0, CCI_STAT_OFS, 0);
    chk("mismatch held", 32'h6, rd);
    pos_lvl <= 8'h40;
    repeat (6) @(posedge clk);
    xfer(0, CCI_FLAG_OFS, 0);
    chk("no flag on return", 32'h0, rd);
    pos_lvl <= 8'h90;
    repeat (6) @(posedge clk);
    xfer(1, CCI_CTRL_OFS, 32'ha0);
    xfer(1, CCI_FLAG_OFS, 0);
    xfer(0, CCI_STAT_OFS, 0);
    chk("latches after write", 32'h3, rd);
    pos_lvl <= 8'h40;
    repeat (6) @(posedge clk);
    xfer(0, CCI_FLAG_OFS, 0);
    chk("flag on return", 32'h1, rd);
    xfer(1, CCI_EN_OFS, 32'h3);
    chk("irq no global", 1'b0, core_irq);
    sleeping <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("wake", 1'b1, wake_req);
    sleeping <= 1'b0;
    xfer(1, CCI_FLAG_OFS, 0);
    xfer(1, CCI_FLAG_OFS, 1);
    xfer(0, CCI_FLAG_OFS, 0);
    chk("flag by software", 32'h1, rd);
    xfer(1, CCI_CTRL_OFS, 0);
    chk("comparator off", 1'b0, comparator_enable);
    close_out;
  end
endmodule // tb_top
